/* File: inc/cfg_pkg.sv */
package cfg_pkg;

    localparam int          WORD_W        = 32;
    localparam int          ADDR_W        = 4;
    localparam int          PAYLOAD_W     = 28;

    // register addresses carried in the low nibble of each word
    localparam logic [3:0]  ADDR_CHAN4    = 4'h4;
    localparam logic [3:0]  ADDR_INBUF    = 4'h5;
    localparam logic [3:0]  ADDR_SECAUX   = 4'h6;
    localparam logic [3:0]  ADDR_DIAG     = 4'h7;

    // values after reset (payload bits 0..27)
    localparam logic [27:0] RST_CHAN4     = 28'h0000000;
    localparam logic [27:0] RST_INBUF     = 28'h0000090;
    localparam logic [27:0] RST_SECAUX    = 28'h0000000;
    localparam logic [27:0] RST_DIAG      = 28'h0000000;

    // output four fields
    localparam int          C4_SRC_LSB    = 4;
    localparam int          C4_PHASE_LSB  = 6;
    localparam int          C4_RATIO_LSB  = 13;
    localparam int          C4_DIV_ON     = 20;
    localparam int          C4_SWING      = 21;
    localparam int          C4_PMODE_LSB  = 22;
    localparam int          C4_NMODE_LSB  = 24;
    localparam int          C4_BUF_LSB    = 22;
    localparam int          C4_SE_LSB     = 26;

    // output buffer patterns, payload bits 27 down to 22
    localparam logic [5:0]  BUF_PAT_PECL  = 6'h20;
    localparam logic [5:0]  BUF_PAT_LVDS  = 6'h3A;
    localparam logic [5:0]  BUF_PAT_OFF   = 6'h1A;

    // input buffer fields
    localparam int          IN_FMT_LSB    = 0;
    localparam int          IN_ALIGN_LSB  = 2;
    localparam int          IN_DC         = 6;
    localparam int          IN_HYST       = 7;
    localparam int          IN_PRI_TERM   = 8;
    localparam int          IN_PRI_BIAS   = 9;
    localparam int          IN_SEC_BIAS   = 10;
    localparam int          IN_FAILSAFE   = 11;

    // register six and seven fields
    localparam int          SA_SEC_TERM   = 12;
    localparam int          SA_AUX_ON     = 24;
    localparam int          SA_AUX_SRC    = 25;
    localparam int          DG_SEL_ONE    = 22;
    localparam int          DG_SEL_TWO    = 24;
    localparam int          DG_UNLOCK     = 26;
    localparam int          DG_NVM_STATE  = 27;

    localparam logic [1:0]  CODE_00       = 2'h0;
    localparam logic [1:0]  CODE_01       = 2'h1;
    localparam logic [1:0]  CODE_10       = 2'h2;
    localparam logic [1:0]  CODE_11       = 2'h3;

    typedef enum logic [2:0] {
        BUF_LVPECL,
        BUF_LVDS,
        BUF_LVCMOS,
        BUF_OFF,
        BUF_UNDEF
    } buf_kind_t;

    typedef struct packed {
        logic invert;
        logic force_low;
        logic hiz;
    } pin_ctl_t;

endpackage : cfg_pkg

/* File: core/clock_fanout_config_regs.sv */
// Notes on behaviour
// - two-bit field picks divider four source
// - pin mode: true, inverted, low, high impedance
// - bits 22..27 pick buffer type
// - ratio bits 13..19, phase bits 6..12
// - divider enable bit: 1 on, 0 off
// - format field: LVPECL, LVDS or LVCMOS
// - two-bit field picks divider alignment clock
// - coupling bit: 1 DC, 0 AC
// - hysteresis bit enables input hysteresis
// - primary termination on when bit is 0
// - primary negative pin biased when bit set
// - secondary negative pin biased when bit set
// - failsafe only for LVDS with DC coupling
// - secondary termination on when bit 12 is 0
// - auxiliary output on when bit 24 set
// - auxiliary fed from divider two or three
module clock_fanout_config_regs
    import cfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        cfg_valid,
    input  wire logic [31:0] cfg_word,
    input  wire logic        rd_req,
    input  wire logic [3:0]  rd_addr,
    input  wire logic        nvm_status_pin,
    output logic             rd_valid,
    output logic [31:0]      rd_data,
    output logic [2:0]       chan4_source_onehot,
    output logic [6:0]       chan4_coarse_phase,
    output logic [6:0]       chan4_ratio,
    output logic             chan4_divider_on,
    output logic             chan4_high_swing,
    output logic [2:0]       chan4_buffer_type,
    output logic [2:0]       chan4_pos_pin,
    output logic [2:0]       chan4_neg_pin,
    output logic [2:0]       input_format_onehot,
    output logic [2:0]       divider_align_onehot,
    output logic             input_coupling_dc,
    output logic             input_hysteresis_on,
    output logic             primary_term_on,
    output logic             primary_neg_bias,
    output logic             secondary_neg_bias,
    output logic             lvds_failsafe_on,
    output logic             secondary_term_on,
    output logic             extra_output_on,
    output logic             extra_output_from_div3,
    output logic             diag_select_one,
    output logic             diag_select_two,
    output logic             nvm_write_unlock
);

    typedef struct packed {
        logic [27:0] chan4;
        logic [27:0] inbuf;
        logic [27:0] secaux;
        logic [27:0] diag;
        logic        nvm_meta;
        logic        nvm_sync;
        logic        rd_valid;
        logic [31:0] rd_data;
        logic [2:0]  src_oh;
        buf_kind_t   buf_kind;
        pin_ctl_t    pos_pin;
        pin_ctl_t    neg_pin;
        logic [2:0]  fmt_oh;
        logic [2:0]  align_oh;
        logic        term_pri_on;
        logic        term_sec_on;
        logic        failsafe;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    function automatic pin_ctl_t pin_decode(input logic [1:0] mode);
        pin_ctl_t p;
        p = '0;
        case (mode)
            CODE_10: p.invert    = 1'b1;
            CODE_11: p.force_low = 1'b1;
            CODE_01: p.hiz       = 1'b1;
            default: p           = '0;
        endcase
        return p;
    endfunction : pin_decode

    // two-bit codes are written X then Y, with X in the lower payload bit
    function automatic logic [1:0] code_of(input logic [1:0] field);
        return {field[0], field[1]};
    endfunction : code_of

    always_comb begin
        logic [27:0] pay;
        logic [3:0]  wa;
        logic [5:0]  bsel;
        pay    = cfg_word[31:4];
        wa     = cfg_word[3:0];
        bsel   = 6'h00;
        st_nxt = st_r;

        // level from another domain, two flops before use
        st_nxt.nvm_meta = nvm_status_pin;
        st_nxt.nvm_sync = st_r.nvm_meta;

        // address nibble selects the target register
        if (cfg_valid) begin
            if (wa == ADDR_CHAN4) begin
                st_nxt.chan4 = pay;
            end else if (wa == ADDR_INBUF) begin
                st_nxt.inbuf = pay;
            end else if (wa == ADDR_SECAUX) begin
                st_nxt.secaux = pay;
            end else if (wa == ADDR_DIAG) begin
                // bit 27 is live status, never stored from the host
                st_nxt.diag = {1'b0, pay[26:0]};
            end
        end

        // readback returns the word in write format
        st_nxt.rd_valid = rd_req;
        if (rd_req) begin
            if (rd_addr == ADDR_CHAN4) begin
                st_nxt.rd_data = {st_r.chan4, rd_addr};
            end else if (rd_addr == ADDR_INBUF) begin
                st_nxt.rd_data = {st_r.inbuf, rd_addr};
            end else if (rd_addr == ADDR_SECAUX) begin
                st_nxt.rd_data = {st_r.secaux, rd_addr};
            end else if (rd_addr == ADDR_DIAG) begin
                st_nxt.rd_data = {st_r.nvm_sync, st_r.diag[26:0], rd_addr};
            end else begin
                st_nxt.rd_data = {28'h0000000, rd_addr};
            end
        end

        // reset lands before the decoders so outputs show the reset decode at once
        if (srst) begin
            st_nxt        = '0;
            st_nxt.chan4  = RST_CHAN4;
            st_nxt.inbuf  = RST_INBUF;
            st_nxt.secaux = RST_SECAUX;
            st_nxt.diag   = RST_DIAG;
        end

        // source route, reserved code selects nothing
        case (code_of(st_nxt.chan4[C4_SRC_LSB +: 2]))
            CODE_00: st_nxt.src_oh = 3'h1;
            CODE_01: st_nxt.src_oh = 3'h2;
            CODE_10: st_nxt.src_oh = 3'h4;
            default: st_nxt.src_oh = 3'h0;
        endcase

        bsel = st_nxt.chan4[C4_BUF_LSB +: 6];
        if (bsel == BUF_PAT_PECL) begin
            st_nxt.buf_kind = BUF_LVPECL;
        end else if (bsel == BUF_PAT_LVDS) begin
            st_nxt.buf_kind = BUF_LVDS;
        end else if (bsel == BUF_PAT_OFF) begin
            st_nxt.buf_kind = BUF_OFF;
        end else if (bsel[5:4] == CODE_00) begin
            st_nxt.buf_kind = BUF_LVCMOS;
        end else begin
            st_nxt.buf_kind = BUF_UNDEF;
        end

        // pin fields only act in single-ended operation
        if (st_nxt.buf_kind == BUF_LVCMOS) begin
            st_nxt.pos_pin = pin_decode(code_of(st_nxt.chan4[C4_PMODE_LSB +: 2]));
            st_nxt.neg_pin = pin_decode(code_of(st_nxt.chan4[C4_NMODE_LSB +: 2]));
        end else begin
            st_nxt.pos_pin = '0;
            st_nxt.neg_pin = '0;
        end

        case (code_of(st_nxt.inbuf[IN_FMT_LSB +: 2]))
            CODE_01: st_nxt.fmt_oh = 3'h1;
            CODE_11: st_nxt.fmt_oh = 3'h2;
            CODE_00: st_nxt.fmt_oh = 3'h4;
            default: st_nxt.fmt_oh = 3'h0;
        endcase

        case (code_of(st_nxt.inbuf[IN_ALIGN_LSB +: 2]))
            CODE_10: st_nxt.align_oh = 3'h1;
            CODE_01: st_nxt.align_oh = 3'h2;
            CODE_00: st_nxt.align_oh = 3'h4;
            default: st_nxt.align_oh = 3'h0;
        endcase

        // termination select bits are active low
        st_nxt.term_pri_on = ~st_nxt.inbuf[IN_PRI_TERM];
        st_nxt.term_sec_on = ~st_nxt.secaux[SA_SEC_TERM];

        // failsafe gated by LVDS format and DC coupling
        st_nxt.failsafe = st_nxt.inbuf[IN_FAILSAFE] && st_nxt.inbuf[IN_DC]
                          && (st_nxt.inbuf[IN_FMT_LSB +: 2] == CODE_11);
    end

    always_ff @(posedge core_clk) begin
        st_r <= st_nxt;
    end

    // every output is a plain flop of the state word, so no decode glitches reach pins
    assign rd_valid               = st_r.rd_valid;
    assign rd_data                = st_r.rd_data;
    assign chan4_source_onehot    = st_r.src_oh;
    assign chan4_coarse_phase     = st_r.chan4[C4_PHASE_LSB +: 7];
    assign chan4_ratio            = st_r.chan4[C4_RATIO_LSB +: 7];
    assign chan4_divider_on       = st_r.chan4[C4_DIV_ON];
    assign chan4_high_swing       = st_r.chan4[C4_SWING];
    assign chan4_buffer_type      = st_r.buf_kind;
    assign chan4_pos_pin          = st_r.pos_pin;
    assign chan4_neg_pin          = st_r.neg_pin;
    assign input_format_onehot    = st_r.fmt_oh;
    assign divider_align_onehot   = st_r.align_oh;
    assign input_coupling_dc      = st_r.inbuf[IN_DC];
    assign input_hysteresis_on    = st_r.inbuf[IN_HYST];
    assign primary_term_on        = st_r.term_pri_on;
    assign primary_neg_bias       = st_r.inbuf[IN_PRI_BIAS];
    assign secondary_neg_bias     = st_r.inbuf[IN_SEC_BIAS];
    assign lvds_failsafe_on       = st_r.failsafe;
    assign secondary_term_on      = st_r.term_sec_on;
    assign extra_output_on        = st_r.secaux[SA_AUX_ON];
    assign extra_output_from_div3 = st_r.secaux[SA_AUX_SRC];
    assign diag_select_one        = st_r.diag[DG_SEL_ONE];
    assign diag_select_two        = st_r.diag[DG_SEL_TWO];
    assign nvm_write_unlock       = st_r.diag[DG_UNLOCK];

    property p_word_store;
        @(posedge core_clk) disable iff (srst)
        (cfg_valid && cfg_word[3:0] == ADDR_CHAN4) |=> (st_r.chan4 == $past(cfg_word[31:4]));
    endproperty
    a_word_store: assert property (p_word_store) else $error("word not stored");

    property p_src;
        @(posedge core_clk) disable iff (srst)
        (cfg_valid && cfg_word[3:0] == ADDR_CHAN4 && {cfg_word[8], cfg_word[9]} == CODE_01)
            |=> (chan4_source_onehot == 3'h2);
    endproperty
    a_src: assert property (p_src) else $error("source not secondary");

    property p_pin_hiz;
        @(posedge core_clk) disable iff (srst)
        (cfg_valid && cfg_word[3:0] == ADDR_CHAN4 && cfg_word[31:30] == CODE_00
            && {cfg_word[26], cfg_word[27]} == CODE_01) |=> (chan4_pos_pin == 3'h1);
    endproperty
    a_pin_hiz: assert property (p_pin_hiz) else $error("pin not high impedance");

    property p_buf_off;
        @(posedge core_clk) disable iff (srst)
        (cfg_valid && cfg_word[3:0] == ADDR_CHAN4 && cfg_word[31:26] == BUF_PAT_OFF)
            |=> (chan4_buffer_type == BUF_OFF && chan4_pos_pin == 3'h0);
    endproperty
    a_buf_off: assert property (p_buf_off) else $error("buffer not off");

    property p_ratio;
        @(posedge core_clk) disable iff (srst)
        (cfg_valid && cfg_word[3:0] == ADDR_CHAN4)
            |=> (chan4_ratio == $past(cfg_word[23:17]) && chan4_divider_on == $past(cfg_word[24]));
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio or enable wrong");

    property p_align;
        @(posedge core_clk) disable iff (srst)
        (cfg_valid && cfg_word[3:0] == ADDR_INBUF && {cfg_word[6], cfg_word[7]} == CODE_10)
            |=> (divider_align_onehot == 3'h1);
    endproperty
    a_align: assert property (p_align) else $error("align not primary");

    property p_fmt;
        @(posedge core_clk) disable iff (srst)
        (cfg_valid && cfg_word[3:0] == ADDR_INBUF && {cfg_word[4], cfg_word[5]} == CODE_01)
            |=> (input_format_onehot == 3'h1);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format not LVPECL");

    property p_failsafe;
        @(posedge core_clk) disable iff (srst)
        lvds_failsafe_on |-> (input_coupling_dc && input_format_onehot == 3'h2);
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("failsafe outside LVDS DC");

    property p_term;
        @(posedge core_clk) disable iff (srst)
        (primary_term_on != st_r.inbuf[IN_PRI_TERM])
            && (secondary_term_on != st_r.secaux[SA_SEC_TERM]);
    endproperty
    a_term: assert property (p_term) else $error("termination polarity wrong");

    property p_read;
        @(posedge core_clk) disable iff (srst)
        (rd_req && rd_addr == ADDR_SECAUX) |=> (rd_valid && rd_data[31:4] == $past(st_r.secaux));
    endproperty
    a_read: assert property (p_read) else $error("readback mismatch");

endmodule : clock_fanout_config_regs

/* File: tb/host_model.sv */
module host_model
    import cfg_pkg::*;
(
    input  wire logic        core_clk,
    output logic             cfg_valid,
    output logic [31:0]      cfg_word,
    output logic             rd_req,
    output logic [3:0]       rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cfg_valid = 1'b0;
        cfg_word  = 32'h0;
        rd_req    = 1'b0;
        rd_addr   = 4'h0;
    end

    // the host owns the reserved bits, so it forces them before sending
    function automatic logic [31:0] legal(input logic [31:0] w);
        logic [31:0] r;
        r = w;
        if (w[3:0] == ADDR_CHAN4) r[7:4] = 4'h0;
        if (w[3:0] == ADDR_INBUF) r[31:16] = 16'h0;
        if (w[3:0] == ADDR_INBUF) r[9:8] = 2'h1;
        return r;
    endfunction : legal

    // address nibble low
    // one clock of host activity; idle lines carry the inverse of their last value
    task automatic step(input logic wv, input logic [31:0] w, input logic rv,
                        input logic [3:0] a);
        cfg_valid = wv;
        cfg_word  = wv ? legal(w) : ~cfg_word;
        rd_req    = rv;
        rd_addr   = rv ? a : ~rd_addr;
        @(negedge core_clk);
    endtask : step
endmodule : host_model

/* File: tb/clock_fanout_config_regs_bench.sv */
module clock_fanout_config_regs_bench
    import cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] data;
        logic [45:0] outs;
        logic        full;
    } note_t;

    logic        core_clk, srst, nvm_status_pin, pin_m;
    logic        cfg_valid, rd_req, rd_valid;
    logic [31:0] cfg_word, rd_data;
    logic [3:0]  rd_addr;
    logic [6:0]  chan4_coarse_phase, chan4_ratio;
    logic [2:0]  chan4_source_onehot, chan4_buffer_type, chan4_pos_pin, chan4_neg_pin;
    logic [2:0]  input_format_onehot, divider_align_onehot;
    logic        chan4_divider_on, chan4_high_swing, input_coupling_dc, input_hysteresis_on;
    logic        primary_term_on, primary_neg_bias, secondary_neg_bias, lvds_failsafe_on;
    logic        secondary_term_on, extra_output_on, extra_output_from_div3;
    logic        diag_select_one, diag_select_two, nvm_write_unlock;
    logic [45:0] outs;
    logic [27:0] pay [4:7];
    logic [27:0] r;
    logic [5:0]  pat;
    note_t       nt;
    note_t       notes [$];
    int          error_cnt, compares, cycles;

    assign outs = {chan4_source_onehot, chan4_coarse_phase, chan4_ratio, chan4_divider_on,
                   chan4_high_swing, chan4_buffer_type, chan4_pos_pin, chan4_neg_pin,
                   input_format_onehot, divider_align_onehot, input_coupling_dc,
                   input_hysteresis_on, primary_term_on, primary_neg_bias, secondary_neg_bias,
                   lvds_failsafe_on, secondary_term_on, extra_output_on, extra_output_from_div3,
                   diag_select_one, diag_select_two, nvm_write_unlock};

    clock_fanout_config_regs u_clock_fanout_config_regs (
        .core_clk, .srst, .cfg_valid, .cfg_word, .rd_req, .rd_addr, .nvm_status_pin,
        .rd_valid, .rd_data, .chan4_source_onehot, .chan4_coarse_phase, .chan4_ratio,
        .chan4_divider_on, .chan4_high_swing, .chan4_buffer_type, .chan4_pos_pin,
        .chan4_neg_pin, .input_format_onehot, .divider_align_onehot, .input_coupling_dc,
        .input_hysteresis_on, .primary_term_on, .primary_neg_bias, .secondary_neg_bias,
        .lvds_failsafe_on, .secondary_term_on, .extra_output_on, .extra_output_from_div3,
        .diag_select_one, .diag_select_two, .nvm_write_unlock
    );

    host_model u_host_model (.core_clk, .cfg_valid, .cfg_word, .rd_req, .rd_addr);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // codes are written X then Y, and X sits in the lower payload bit
    function automatic logic [1:0] xy(input logic [1:0] f);
        return {f[0], f[1]};
    endfunction : xy

    function automatic logic [2:0] tab(input logic [1:0] c, input logic [11:0] t);
        return t[c * 3 +: 3];
    endfunction : tab

    function automatic logic [45:0] decode();
        logic [27:0] p4, p5, p6, p7;
        logic [2:0]  bt;
        logic        cm;
        p4 = pay[4];
        p5 = pay[5];
        p6 = pay[6];
        p7 = pay[7];
        bt = (p4[27:22] == BUF_PAT_PECL) ? BUF_LVPECL : (p4[27:22] == BUF_PAT_LVDS) ? BUF_LVDS
           : (p4[27:22] == BUF_PAT_OFF) ? BUF_OFF : (p4[27:26] == 2'h0) ? BUF_LVCMOS : BUF_UNDEF;
        cm = (bt == BUF_LVCMOS);
        return {tab(xy(p4[5:4]), 12'h111), p4[12:6], p4[19:13], p4[20], p4[21], bt,
                cm ? tab(xy(p4[23:22]), 12'h508) : 3'h0, cm ? tab(xy(p4[25:24]), 12'h508) : 3'h0,
                tab(xy(p5[1:0]), 12'h40C), tab(xy(p5[3:2]), 12'h054), p5[6], p5[7], ~p5[8],
                p5[9], p5[10], p5[11] & p5[6] & (p5[1:0] == 2'h3), ~p6[12], p6[24], p6[25],
                p7[22], p7[24], p7[26]};
    endfunction : decode

    function automatic logic [31:0] rdexp(input logic [3:0] a);
        if (a[3:2] != 2'h1) return {28'h0, a};
        if (a == ADDR_DIAG) return {pin_m, pay[7][26:0], a};
        return {pay[a], a};
    endfunction : rdexp

    task automatic reset_model();
        pay[4] = RST_CHAN4;
        pay[5] = RST_INBUF;
        pay[6] = RST_SECAUX;
        pay[7] = RST_DIAG;
    endtask : reset_model

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // full marks a read whose output snapshot is settled and worth comparing
    task automatic op(input logic wv, input logic [3:0] wa, input logic [27:0] wp,
                      input logic rv, input logic [3:0] ra, input logic full);
        logic [31:0] w;
        w = u_host_model.legal({wp, wa});
        if (rv) notes.push_back({rdexp(ra), decode(), full});
        u_host_model.step(wv, w, rv, ra);
        if (wv && wa[3:2] == 2'h1) pay[wa] = w[31:4];
    endtask : op

    task automatic idle();
        op(1'b0, 4'h0, 28'h0, 1'b0, 4'h0, 1'b0);
    endtask : idle

    task automatic wr_rd(input logic [3:0] a, input logic [27:0] p);
        op(1'b1, a, p, 1'b0, 4'h0, 1'b0);
        op(1'b0, 4'h0, 28'h0, 1'b1, a, 1'b1);
        idle();
    endtask : wr_rd

    task automatic read_all();
        for (int a = 0; a < 16; a++) op(1'b0, 4'h0, 28'h0, 1'b1, 4'(a), 1'b1);
        idle();
    endtask : read_all

    task automatic complete_run();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    always @(negedge core_clk) begin
        if (rd_valid === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unrequested rd_valid", 64'h0, 64'h1);
            end else begin
                nt = notes.pop_front();
                chk("rd_data", 64'(nt.data), 64'(rd_data));
                if (nt.full) chk("outputs", 64'(nt.outs), 64'(outs));
            end
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        srst = 1'b1;
        nvm_status_pin = 1'b0;
        pin_m = 1'b0;
        reset_model();
        void'($urandom(26044));
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        read_all();
        for (int i = 0; i < 8; i++) begin
            pat = (i == 0) ? BUF_PAT_PECL : (i == 1) ? BUF_PAT_LVDS : (i == 2) ? BUF_PAT_OFF
                : {2'h0, 2'(i), ~2'(i)};
            wr_rd(ADDR_CHAN4, {pat, 22'($urandom)});
        end
        for (int i = 0; i < 16; i++) begin
            r = 28'($urandom);
            r[1:0] = 2'(i);
            r[6] = i[2];
            r[11] = i[3];
            wr_rd(ADDR_INBUF, r);
        end
        for (int i = 0; i < 60; i++) wr_rd(4'($urandom), 28'($urandom));
        // back to back writes, then read and write of one register in one cycle
        op(1'b1, ADDR_SECAUX, 28'($urandom), 1'b0, 4'h0, 1'b0);
        op(1'b1, ADDR_DIAG, 28'($urandom), 1'b1, ADDR_SECAUX, 1'b0);
        op(1'b1, ADDR_CHAN4, 28'($urandom), 1'b1, ADDR_CHAN4, 1'b0);
        read_all();
        nvm_status_pin = 1'b1;
        pin_m = 1'b1;
        repeat (3) idle();
        read_all();
        srst = 1'b1;
        reset_model();
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        read_all();
        repeat (2) idle();
        chk("pending reads", 64'h0, 64'(notes.size()));
        complete_run();
    end
endmodule : clock_fanout_config_regs_bench
